// ===== logic/fault_escalation_lockup.sv
// fault classification, status capture, escalation and lockup control
`timescale 1ns/10ps
module fault_escalation_lockup (
    input  wire logic                          clock_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          enable_i,
    // fault sources
    input  wire logic                          vector_bus_err_i,
    input  wire logic                          fetch_bus_err_i,
    input  wire logic                          load_bus_err_i,
    input  wire logic                          store_bus_err_i,
    input  wire logic                          cache_maint_err_i,
    input  wire logic                          stack_bus_err_i,
    input  wire logic                          unstack_bus_err_i,
    input  wire logic                          lazyfp_bus_err_i,
    input  wire logic                          debug_bus_err_i,
    input  wire logic [fault_pkg::AV_W-1:0]    access_viol_i,
    input  wire logic                          never_execute_attribute_i,
    input  wire logic [fault_pkg::MU_W-1:0]    misuse_i,
    input  wire logic [fault_pkg::ADDR_W-1:0]  fault_addr_i,
    // execution context
    input  wire fault_pkg::exec_ctx_t          exec_ctx_i,
    input  wire logic [fault_pkg::PRIO_W-1:0]  cur_prio_i,
    input  wire logic                          nmi_i,
    input  wire logic                          debug_halt_i,
    // configuration
    input  wire logic [fault_pkg::PRIO_W-1:0]  access_prio_i,
    input  wire logic [fault_pkg::PRIO_W-1:0]  bus_prio_i,
    input  wire logic [fault_pkg::PRIO_W-1:0]  misuse_prio_i,
    input  wire logic                          access_en_i,
    input  wire logic                          bus_en_i,
    input  wire logic                          misuse_en_i,
    // software clears, one bit per flag
    input  wire logic [fault_pkg::AV_W-1:0]    av_clear_i,
    input  wire logic [fault_pkg::BE_W-1:0]    be_clear_i,
    input  wire logic [fault_pkg::SF_W-1:0]    sf_clear_i,
    input  wire logic [fault_pkg::MU_W-1:0]    mu_clear_i,
    // outputs
    output fault_pkg::fault_class_t            take_class_o,
    output logic                               pend_async_bus_o,
    output logic                               pend_async_severe_o,
    output logic                               debug_err_o,
    output logic [fault_pkg::AV_W-1:0]         access_violation_status_o,
    output logic [fault_pkg::BE_W-1:0]         bus_error_status_o,
    output logic [fault_pkg::SF_W-1:0]         severe_fault_status_o,
    output logic [fault_pkg::MU_W-1:0]         instruction_misuse_status_o,
    output logic [fault_pkg::ADDR_W-1:0]       access_violation_address_o,
    output logic [fault_pkg::ADDR_W-1:0]       bus_error_address_o,
    output logic                               lockup_o
);
    import fault_pkg::*;

    logic [AV_W-1:0]   av;
    logic [BE_W-1:0]   be;
    logic [SF_W-1:0]   sf;
    logic [MU_W-1:0]   mu;
    logic [ADDR_W-1:0] av_addr;
    logic [ADDR_W-1:0] be_addr;
    logic              lockup;
    logic              lock_from_nmi;
    fault_class_t      take_class;
    logic              pend_bus;
    logic              pend_sev;
    logic              dbg_err;
    logic [AV_W-1:0]   next_av;
    logic [BE_W-1:0]   next_be;
    logic [SF_W-1:0]   next_sf;
    logic [MU_W-1:0]   next_mu;
    logic [ADDR_W-1:0] next_av_addr;
    logic [ADDR_W-1:0] next_be_addr;
    logic              next_lockup;
    logic              next_lock_from_nmi;
    fault_class_t      next_take_class;
    logic              next_pend_bus;
    logic              next_pend_sev;
    logic              next_dbg_err;

    logic [AV_W-1:0] av_raise;
    logic [BE_W-1:0] be_raise;
    logic            av_any;
    logic            be_sync;
    logic            mu_any;
    logic            av_esc;
    logic            av_take;
    logic            be_esc;
    logic            be_take;
    logic            mu_esc;
    logic            mu_take;
    logic            in_handler;
    logic            in_critical;
    logic            exempt;
    logic            any_sync;
    logic            vect_err;

    // pipeline sources; debugger errors never reach exception logic
    always_comb begin
        av_raise = access_viol_i;
        av_raise[AV_INSTR] = access_viol_i[AV_INSTR] | never_execute_attribute_i;
        be_raise = '0;
        be_raise[BE_STACK]  = stack_bus_err_i;
        be_raise[BE_UNSTK]  = unstack_bus_err_i;
        be_raise[BE_PREF]   = fetch_bus_err_i;
        be_raise[BE_LAZYFP] = lazyfp_bus_err_i;
        be_raise[BE_EXACT]  = load_bus_err_i;
        // stores and cache maintenance complete after retirement, so async
        be_raise[BE_INEXACT] = store_bus_err_i | cache_maint_err_i;
        vect_err   = vector_bus_err_i;
        av_any     = |av_raise;
        be_sync    = |be_raise[BE_EXACT:BE_STACK];
        mu_any     = |misuse_i;
        in_handler = exec_ctx_i != CTX_THREAD;
        in_critical = (exec_ctx_i == CTX_NMI) || (exec_ctx_i == CTX_SEVERE);
        // stacking error while entering the bus handler is let through
        exempt     = stack_bus_err_i && (exec_ctx_i == CTX_BUS);
        any_sync   = av_any || be_sync || mu_any || vect_err;
    end

    fault_escalate u_av_esc (
        .raise_i      (av_any),
        .enabled_i    (access_en_i),
        .fault_prio_i (access_prio_i),
        .cur_prio_i   (cur_prio_i),
        .in_handler_i (in_handler),
        .same_kind_i  (exec_ctx_i == CTX_ACCESS),
        .exempt_i     (1'b0),
        .escalate_o   (av_esc),
        .take_o       (av_take)
    );

    fault_escalate u_be_esc (
        .raise_i      (be_sync),
        .enabled_i    (bus_en_i),
        .fault_prio_i (bus_prio_i),
        .cur_prio_i   (cur_prio_i),
        .in_handler_i (in_handler),
        .same_kind_i  (exec_ctx_i == CTX_BUS),
        .exempt_i     (exempt),
        .escalate_o   (be_esc),
        .take_o       (be_take)
    );

    fault_escalate u_mu_esc (
        .raise_i      (mu_any),
        .enabled_i    (misuse_en_i),
        .fault_prio_i (misuse_prio_i),
        .cur_prio_i   (cur_prio_i),
        .in_handler_i (in_handler),
        .same_kind_i  (exec_ctx_i == CTX_MISUSE),
        .exempt_i     (1'b0),
        .escalate_o   (mu_esc),
        .take_o       (mu_take)
    );

    always_comb begin
        // set wins over clear on every sticky flag
        next_av = (av & ~av_clear_i) | av_raise;
        next_be = (be & ~be_clear_i) | be_raise;
        next_mu = (mu & ~mu_clear_i) | misuse_i;
        next_sf = sf & ~sf_clear_i;
        next_av_addr = av_addr;
        next_be_addr = be_addr;
        next_take_class = FC_NONE;
        next_pend_bus = 1'b0;
        next_pend_sev = 1'b0;
        next_dbg_err  = debug_bus_err_i;
        next_lockup = lockup;
        next_lock_from_nmi = lock_from_nmi;
        if (vect_err) begin
            next_sf[SF_VECT] = 1'b1;
        end
        if (av_esc || be_esc || mu_esc) begin
            next_sf[SF_ESCALATION_FLAG_A] = 1'b1;
        end
        // only data and instruction violations carry a meaningful address
        if (av_raise[AV_DATA] || av_raise[AV_INSTR]) begin
            next_av_addr = fault_addr_i;
        end
        // every synchronous bus error names the access that failed
        if (be_sync) begin
            next_be_addr = fault_addr_i;
        end
        // the severe fault outranks the configurable classes
        if (in_critical && any_sync) begin
            next_take_class = FC_NONE;
        end else if (vect_err || av_esc || be_esc || mu_esc) begin
            next_take_class = FC_SEVERE;
        end else if (av_take) begin
            next_take_class = FC_ACCESS;
        end else if (be_take) begin
            next_take_class = FC_BUS;
        end else if (mu_take) begin
            next_take_class = FC_MISUSE;
        end
        // asynchronous errors pend regardless of the running handler
        if (be_raise[BE_INEXACT]) begin
            next_pend_bus = bus_en_i;
            next_pend_sev = !bus_en_i;
        end
        if (lockup) begin
            if (debug_halt_i || (nmi_i && !lock_from_nmi)) begin
                next_lockup = 1'b0;
                next_lock_from_nmi = 1'b0;
            end
        end else if (in_critical && any_sync) begin
            // async pends never lock up, only synchronous faults do
            next_lockup = 1'b1;
            next_lock_from_nmi = exec_ctx_i == CTX_NMI;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            av <= AV_RESET;
            be <= BE_RESET;
            sf <= SF_RESET;
            mu <= MU_RESET;
            av_addr <= ADDR_RESET;
            be_addr <= ADDR_RESET;
            lockup <= 1'b0;
            lock_from_nmi <= 1'b0;
            take_class <= FC_NONE;
            pend_bus <= 1'b0;
            pend_sev <= 1'b0;
            dbg_err <= 1'b0;
        end else if (enable_i) begin
            av <= next_av;
            be <= next_be;
            sf <= next_sf;
            mu <= next_mu;
            av_addr <= next_av_addr;
            be_addr <= next_be_addr;
            lockup <= next_lockup;
            lock_from_nmi <= next_lock_from_nmi;
            take_class <= next_take_class;
            pend_bus <= next_pend_bus;
            pend_sev <= next_pend_sev;
            dbg_err <= next_dbg_err;
        end
    end

    assign take_class_o = take_class;
    assign pend_async_bus_o = pend_bus;
    assign pend_async_severe_o = pend_sev;
    assign debug_err_o = dbg_err;
    assign access_violation_status_o = av;
    assign bus_error_status_o = be;
    assign severe_fault_status_o = sf;
    assign instruction_misuse_status_o = mu;
    assign access_violation_address_o = av_addr;
    assign bus_error_address_o = be_addr;
    assign lockup_o = lockup;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    AST_VECT_FLAG: assert property (enable_i && vector_bus_err_i |=>
        severe_fault_status_o[SF_VECT] && take_class_o == FC_SEVERE || lockup_o)
        else $error("vector error did not flag severe fault");
    AST_ESCALATION_FLAG_A: assert property (enable_i && !bus_en_i && load_bus_err_i
        && !in_critical |=> severe_fault_status_o[SF_ESCALATION_FLAG_A])
        else $error("disabled bus handler did not force escalation");
    AST_SAME_KIND: assert property (enable_i && exec_ctx_i == CTX_MISUSE
        && mu_any |=> take_class_o == FC_SEVERE)
        else $error("same kind fault not escalated");
    AST_NO_ESC_STACK: assert property (enable_i && exempt && bus_en_i
        && !av_any && !mu_any && !vect_err |=> take_class_o == FC_BUS)
        else $error("bus stacking error escalated");
    AST_ASYNC_PEND: assert property (enable_i && store_bus_err_i |=>
        (pend_async_bus_o == $past(bus_en_i)) && (pend_async_severe_o != $past(bus_en_i)))
        else $error("async bus error pended wrongly");
    AST_ASYNC_NO_LOCK: assert property (enable_i && !lockup && !any_sync
        |=> !lockup_o)
        else $error("async error caused lockup");
    AST_LOCK_ENTER: assert property (enable_i && in_critical && any_sync
        |=> lockup_o)
        else $error("fault in critical handler did not lock up");
    AST_NMI_STICK: assert property (lockup_o && lock_from_nmi && !debug_halt_i
        |=> lockup_o)
        else $error("nmi released lockup entered from nmi");
    AST_DEBUG_ONLY: assert property (enable_i && debug_bus_err_i && !any_sync
        && !store_bus_err_i && !cache_maint_err_i |=> debug_err_o && take_class_o == FC_NONE)
        else $error("debugger error reached exception logic");
    AST_STICKY: assert property (enable_i && bus_error_status_o[BE_EXACT]
        && !be_clear_i[BE_EXACT] |=> bus_error_status_o[BE_EXACT])
        else $error("status flag lost without clear");
    AST_ADDR: assert property (enable_i && load_bus_err_i |=>
        bus_error_address_o == $past(fault_addr_i))
        else $error("bus error address not captured");

    COV_LOCK: cover property (lockup_o ##1 !lockup_o);
    COV_ESC: cover property (take_class_o == FC_SEVERE && severe_fault_status_o[SF_ESCALATION_FLAG_A]);
    COV_ASYNC: cover property (pend_async_severe_o);
endmodule

// ===== logic/fault_pkg.sv
// shared constants and types for the fault escalation block
package fault_pkg;
    localparam int ADDR_W = 32;
    localparam int PRIO_W = 8;
    // fault class codes reported to the prioritisation logic
    typedef enum logic [2:0] {
        FC_NONE,
        FC_SEVERE,
        FC_ACCESS,
        FC_BUS,
        FC_MISUSE
    } fault_class_t;
    // access violation status bit positions
    localparam int AV_INSTR  = 0;
    localparam int AV_DATA   = 1;
    localparam int AV_STACK  = 2;
    localparam int AV_UNSTK  = 3;
    localparam int AV_LAZYFP = 4;
    localparam int AV_W      = 5;
    // bus error status bit positions
    localparam int BE_STACK  = 0;
    localparam int BE_UNSTK  = 1;
    localparam int BE_PREF   = 2;
    localparam int BE_LAZYFP = 3;
    localparam int BE_EXACT  = 4;
    localparam int BE_INEXACT = 5;
    localparam int BE_W      = 6;
    // severe fault status bit positions
    localparam int SF_VECT   = 0;
    localparam int SF_ESCALATION_FLAG_A = 1;
    localparam int SF_W      = 2;
    localparam int MU_W      = 4;
    // reset values
    localparam logic [AV_W-1:0]   AV_RESET   = 5'h00;
    localparam logic [BE_W-1:0]   BE_RESET   = 6'h00;
    localparam logic [SF_W-1:0]   SF_RESET   = 2'h0;
    localparam logic [MU_W-1:0]   MU_RESET   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    // context of the handler now running
    typedef enum logic [2:0] {
        CTX_THREAD,
        CTX_NMI,
        CTX_SEVERE,
        CTX_ACCESS,
        CTX_BUS,
        CTX_MISUSE,
        CTX_OTHER
    } exec_ctx_t;
endpackage

// ===== logic/fault_escalate.sv
// combinational escalation decision for one configurable fault class
`timescale 1ns/10ps
module fault_escalate (
    input  wire logic                        raise_i,
    input  wire logic                        enabled_i,
    input  wire logic [fault_pkg::PRIO_W-1:0] fault_prio_i,
    input  wire logic [fault_pkg::PRIO_W-1:0] cur_prio_i,
    input  wire logic                        in_handler_i,
    input  wire logic                        same_kind_i,
    input  wire logic                        exempt_i,
    output logic                             escalate_o,
    output logic                             take_o
);
    import fault_pkg::*;

    logic blocked;

    always_comb begin
        // lower numeric value is more urgent; equal priority cannot preempt
        blocked = in_handler_i && (fault_prio_i >= cur_prio_i);
        if (!raise_i) begin
            escalate_o = 1'b0;
        end else if (exempt_i) begin
            escalate_o = 1'b0;
        end else begin
            escalate_o = !enabled_i || same_kind_i || blocked;
        end
        take_o = raise_i && !escalate_o;
    end
endmodule

// ===== dv/fault_source_model.sv
// behavioural model of the fault reporting side: bus fabric, protection unit, debugger
`timescale 1ns/10ps
module fault_source_model (
    input  wire logic        clock_i,
    input  wire logic [4:0]  src_i,
    input  wire logic [31:0] addr_i,
    output logic      [18:0] pulse_o,
    output logic      [31:0] addr_o
);
    logic [31:0] junk = 32'h5a5a_a5a5;
    // one source pulses per cycle, code 5'h1f is quiet
    assign pulse_o = (src_i < 5'h13) ? (19'h1 << src_i) : 19'h0;
    // the address only means something beside a pulse, so it churns otherwise
    always_ff @(posedge clock_i) begin
        junk <= ~junk ^ {junk[30:0], junk[31]};
    end
    assign addr_o = (pulse_o != 19'h0) ? addr_i : junk;
endmodule

// ===== dv/tb_top.sv
// self-checking bench with a cycle model of fault escalation and lockup
`timescale 1ns/10ps
module tb_top;
    import fault_pkg::*;
    logic clock_i = 1'h0, reset_n_i = 1'h0, enable_i = 1'h0, nmi_i = 1'h0, debug_halt_i = 1'h0;
    logic access_en_i = 1'h1, bus_en_i = 1'h1, misuse_en_i = 1'h1, chk_stat = 1'h1;
    exec_ctx_t exec_ctx_i = CTX_THREAD;
    logic [PRIO_W-1:0] cur_prio_i = 8'h0, access_prio_i = 8'h0, bus_prio_i = 8'h0;
    logic [PRIO_W-1:0] misuse_prio_i = 8'h0;
    logic [AV_W-1:0] av_clear_i = 5'h0, access_violation_status_o, m_av;
    logic [BE_W-1:0] be_clear_i = 6'h0, bus_error_status_o, m_be;
    logic [SF_W-1:0] sf_clear_i = 2'h0, severe_fault_status_o, m_sf;
    logic [MU_W-1:0] mu_clear_i = 4'h0, instruction_misuse_status_o, m_mu;
    logic [4:0] src = 5'h1f;
    logic [18:0] pulse;
    logic [ADDR_W-1:0] addr = 32'h0, fault_addr, access_violation_address_o, bus_error_address_o;
    logic [ADDR_W-1:0] m_aa, m_ba;
    fault_class_t take_class_o, e_take;
    logic pend_async_bus_o, pend_async_severe_o, debug_err_o, lockup_o;
    logic e_pb, e_ps, e_dbg, chk_pulse, m_lock, m_lnmi, esc;
    integer error_cnt = 0, total_checks = 0, seed = 32'hc88a, cls, b;
    exec_ctx_t ctx_tab[5] = '{CTX_THREAD, CTX_ACCESS, CTX_BUS, CTX_MISUSE, CTX_OTHER};

    always #50 clock_i = ~clock_i;

    fault_source_model i_src (.clock_i, .src_i(src), .addr_i(addr), .pulse_o(pulse),
        .addr_o(fault_addr));

    fault_escalation_lockup i_dut (.clock_i, .reset_n_i, .enable_i,
        .vector_bus_err_i(pulse[0]), .fetch_bus_err_i(pulse[1]), .load_bus_err_i(pulse[2]),
        .store_bus_err_i(pulse[3]), .cache_maint_err_i(pulse[4]), .stack_bus_err_i(pulse[5]),
        .unstack_bus_err_i(pulse[6]), .lazyfp_bus_err_i(pulse[7]), .debug_bus_err_i(pulse[8]),
        .access_viol_i(pulse[13:9]), .never_execute_attribute_i(pulse[14]),
        .misuse_i(pulse[18:15]), .fault_addr_i(fault_addr), .exec_ctx_i, .cur_prio_i, .nmi_i,
        .debug_halt_i, .access_prio_i, .bus_prio_i, .misuse_prio_i, .access_en_i, .bus_en_i,
        .misuse_en_i, .av_clear_i, .be_clear_i, .sf_clear_i, .mu_clear_i, .take_class_o,
        .pend_async_bus_o, .pend_async_severe_o, .debug_err_o, .access_violation_status_o,
        .bus_error_status_o, .severe_fault_status_o, .instruction_misuse_status_o,
        .access_violation_address_o, .bus_error_address_o, .lockup_o);

    // reference model: clears land first so that a set in the same cycle wins
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {m_av, m_be, m_sf, m_mu, m_aa, m_ba, m_lock, m_lnmi} = '0;
            {e_pb, e_ps, e_dbg, chk_pulse} = 4'h1;
            e_take = FC_NONE;
        end else if (enable_i) begin
            {e_pb, e_ps, e_dbg, chk_pulse} = 4'h1;
            e_take = FC_NONE;
            cls = 0;
            b = 0;
            m_av = m_av & ~av_clear_i;
            m_be = m_be & ~be_clear_i;
            m_sf = m_sf & ~sf_clear_i;
            m_mu = m_mu & ~mu_clear_i;
            esc = 1'h0;
            case (src)
                5'h00: cls = 1;
                5'h01: begin cls = 3; b = BE_PREF; end
                5'h02: begin cls = 3; b = BE_EXACT; end
                5'h05: begin cls = 3; b = BE_STACK; end
                5'h06: begin cls = 3; b = BE_UNSTK; end
                5'h07: begin cls = 3; b = BE_LAZYFP; end
                5'h03, 5'h04: begin
                    m_be[BE_INEXACT] = 1'h1;
                    e_pb = bus_en_i;
                    e_ps = !bus_en_i;
                end
                5'h08: e_dbg = 1'h1;
                5'h0e: cls = 2;
                default: begin
                    if (src >= 5'h09 && src <= 5'h0d) begin cls = 2; b = src - 9; end
                    if (src >= 5'h0f && src <= 5'h12) begin cls = 4; b = src - 15; end
                end
            endcase
            if (cls == 1) m_sf[SF_VECT] = 1'h1;
            if (cls == 2) m_av[b] = 1'h1;
            if (cls == 2 && b <= AV_DATA) m_aa = addr;
            if (cls == 3) m_be[b] = 1'h1;
            if (cls == 3) m_ba = addr;
            if (cls == 4) m_mu[b] = 1'h1;
            // escalation is flagged even when the same fault ends in lockup
            if (cls >= 2) begin
                esc = (cls == 2) ? !access_en_i : (cls == 3) ? !bus_en_i : !misuse_en_i;
                if (exec_ctx_i != CTX_THREAD && ((cls == 2) ? access_prio_i : (cls == 3) ?
                    bus_prio_i : misuse_prio_i) >= cur_prio_i) esc = 1'h1;
                if (int'(exec_ctx_i) == cls + 1) esc = 1'h1;
                if (src == 5'h05 && exec_ctx_i == CTX_BUS) esc = 1'h0;
                if (esc) m_sf[SF_ESCALATION_FLAG_A] = 1'h1;
            end
            if (cls == 0 || !(exec_ctx_i == CTX_NMI || exec_ctx_i == CTX_SEVERE)) begin
                if (cls == 1 || esc) e_take = FC_SEVERE;
                else if (cls != 0) e_take = fault_class_t'(cls);
            end
            // a held lockup only leaves; a fault in that cycle does not re-enter
            if (m_lock) begin
                if (debug_halt_i || (nmi_i && !m_lnmi)) m_lock = 1'h0;
            end else if (cls != 0 && (exec_ctx_i == CTX_NMI || exec_ctx_i == CTX_SEVERE)) begin
                m_lock = 1'h1;
                m_lnmi = (exec_ctx_i == CTX_NMI);
            end
        end else begin
            chk_pulse = 1'h0;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d of %0d checks", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // compare at the falling edge, then the caller drives the next inputs
    task automatic step();
        @(negedge clock_i);
        if (reset_n_i) begin
            if (chk_pulse) begin
                check(32'(take_class_o), 32'(e_take));
                check(32'(pend_async_bus_o), 32'(e_pb));
                check(32'(pend_async_severe_o), 32'(e_ps));
                check(32'(debug_err_o), 32'(e_dbg));
            end
            check(32'(lockup_o), 32'(m_lock));
            if (chk_stat) begin
                check(32'(access_violation_status_o), 32'(m_av));
                check(32'(bus_error_status_o), 32'(m_be));
                check(32'(severe_fault_status_o), 32'(m_sf));
                check(32'(instruction_misuse_status_o), 32'(m_mu));
                check(access_violation_address_o, m_aa);
                check(bus_error_address_o, m_ba);
            end
        end
    endtask

    task automatic drive_rand();
        logic [31:0] r, r2, r3;
        r = $random(seed);
        r2 = $random(seed) | $random(seed);
        r3 = $random(seed) & $random(seed) & $random(seed);
        src = (r[2:0] == 3'h0) ? 5'h1f : 5'(r[20:3] % 18'h13);
        exec_ctx_i = ctx_tab[r[23:21] % 3'h5];
        {cur_prio_i, access_prio_i} = {r[31:24], r2[31:24]};
        {bus_prio_i, misuse_prio_i} = r3[31:16] ^ r[15:0];
        {access_en_i, bus_en_i, misuse_en_i} = r2[2:0];
        enable_i = (r2[10:6] != 5'h0);
        {mu_clear_i, sf_clear_i, be_clear_i, av_clear_i} = r3[16:0];
        addr = $random(seed);
    endtask

    // store stays asynchronous in the handler, a load then locks up, exits follow
    task automatic lock_case(input exec_ctx_t c);
        exec_ctx_i = c;
        src = 5'h03;
        step();
        src = 5'h02;
        step();
        src = 5'h1f;
        exec_ctx_i = CTX_THREAD;
        repeat (3) step();
        nmi_i = 1'h1;
        repeat (2) step();
        nmi_i = 1'h0;
        debug_halt_i = 1'h1;
        step();
        debug_halt_i = 1'h0;
        repeat (2) step();
    endtask

    initial begin
        repeat (16) @(posedge clock_i);
        step();
        reset_n_i = 1'h1;
        enable_i = 1'h1;
        repeat (3000) begin
            step();
            drive_rand();
        end
        step();
        src = 5'h1f;
        reset_n_i = 1'h0;
        repeat (2) step();
        reset_n_i = 1'h1;
        repeat (500) begin
            step();
            drive_rand();
        end
        step();
        chk_stat = 1'h0;
        {enable_i, access_en_i, bus_en_i, misuse_en_i} = 4'hf;
        {mu_clear_i, sf_clear_i, be_clear_i, av_clear_i} = 17'h0;
        lock_case(CTX_SEVERE);
        lock_case(CTX_NMI);
        wrap_up();
    end

    initial begin
        #(100 * 6000);
        error_cnt++;
        wrap_up();
    end
endmodule
